/* File: ppc_board_model.sv */
// Board circuitry and external memory seen from the port pins
`default_nettype none
module ppc_board_model
  import ppc_pkg::*;
(
  input  wire logic                      pclk,
  input  wire ppc_drive_type             gp_pin_drive,
  input  wire logic                      reset_pin_active_low_oe,
  input  wire logic [NUM_BIDIR-1:0][7:0] board_level,
  input  wire logic [7:0]                mem_rdata,
  output logic      [NUM_BIDIR-1:0][7:0] gp_pin_in,
  output logic                           reset_pin_active_low_in
);
  import ppc_pkg::*;
  logic [7:0] float_pat = 8'h5a;
  logic       mem_read;
  logic       bus_sel;

  // Released data lines wander, so a stale value never passes for a drive
  always_ff @(posedge pclk)
  begin
    float_pat <= ~float_pat;
  end

  // Memory answers while read strobe and chip select are both driven low
  assign mem_read = (gp_pin_drive.enable[IDX_P5][2:1] == 2'b11) &&
                    (gp_pin_drive.level[IDX_P5][2:1] == 2'b00);

  // Data lines float only while chip select is driven low; else board level
  assign bus_sel = gp_pin_drive.enable[IDX_P5][2] &&
                   !gp_pin_drive.level[IDX_P5][2];

  // Pin level: device drive wins, then memory, then board or float
  always_comb
  begin
    for (int s = 0; s < NUM_BIDIR; s++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (gp_pin_drive.enable[s][b])
          gp_pin_in[s][b] = gp_pin_drive.level[s][b];
        else if (s == IDX_P8 && mem_read)
          gp_pin_in[s][b] = mem_rdata[b];
        else if (s == IDX_P8 && bus_sel)
          gp_pin_in[s][b] = float_pat[b];
        else
          gp_pin_in[s][b] = board_level[s][b];
      end
    end
  end

  // Internal pull-up holds the reset line high unless pulled low
  assign reset_pin_active_low_in = !reset_pin_active_low_oe;
endmodule // ppc_board_model
`default_nettype wire

/* File: ppc_pkg.sv */
// Constants and carrier types for the port pin control block
`default_nettype none
package ppc_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 40;
  localparam int OSC_STABLE_NS = 1000000;
  localparam int OSC_STABLE_CYC = OSC_STABLE_NS * CLK_MHZ / 1000;
  localparam int SWRST_LOW_NS = 1000;
  localparam int SWRST_LOW_CYC = (SWRST_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_CYC = 3;

  // Bidirectional port slots: 0,1,3,4,5,6,7,8
  localparam int NUM_BIDIR = 8;
  localparam int IDX_P5 = 4;
  localparam int IDX_P6 = 5;
  localparam int IDX_P7 = 6;
  localparam int IDX_P8 = 7;
  localparam int PULL_IDX_P2 = 6;
  localparam logic [7:0] PORT_MASK [NUM_BIDIR] =
    '{8'h7f, 8'h1f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] P2_MASK = 8'h1f;
  localparam int P2_RST_BIT = 7;

  // Register byte offsets
  localparam logic [11:0] OFS_OUT_BASE = 12'h000;
  localparam logic [11:0] OFS_P2_DATA = 12'h020;
  localparam logic [11:0] OFS_PA_DATA = 12'h024;
  localparam logic [11:0] OFS_DIR_BASE = 12'h040;
  localparam logic [11:0] OFS_PULL_BASE = 12'h060;
  localparam logic [11:0] OFS_P7_PUD = 12'h080;
  localparam logic [11:0] OFS_PA_PUD = 12'h084;
  localparam logic [11:0] OFS_SYNC = 12'h090;
  localparam logic [11:0] OFS_SWRST = 12'h094;
  localparam logic [11:0] OFS_STATUS = 12'h098;

  // Field positions and reset values
  localparam int PUD_DOWN_BIT = 8;
  localparam int SYNC_SRC_LSB = 8;
  localparam int STAT_PROC_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic RST_P2_LATCH = 1'b1;

  // Synchronous output trigger sources
  typedef enum logic [1:0] {
    PPC_SRC_IRQ2, PPC_SRC_TMR1, PPC_SRC_TMR2, PPC_SRC_TMR4
  } ppc_src_type;

  // Pin drive carrier: level and enable per port slot
  typedef struct packed {
    logic [NUM_BIDIR-1:0][7:0] level;
    logic [NUM_BIDIR-1:0][7:0] enable;
  } ppc_drive_type;

  // Pull resistor enables
  typedef struct packed {
    logic [NUM_BIDIR-1:0][7:0] up;
    logic [7:0]                p2_up;
    logic [7:0]                p7_down;
    logic [7:0]                pa_up;
    logic [7:0]                pa_down;
  } ppc_pull_type;

  // External memory bus request from the core
  typedef struct packed {
    logic        wr_n;
    logic        rd_n;
    logic        cs_n;
    logic [17:0] addr;
    logic [7:0]  wdata;
  } ppc_ext_req_type;
endpackage
`default_nettype wire

/* File: ppc_port_ctrl.sv */
// Port pin control with external bus takeover and reset pin
// Behaviour
// - Ports 0,1 are 7 and 5 bits; 3,4,6,7,8 eight; 2 five, A eight input
// - Every bidirectional bit has its own direction bit
// - Ports 0-6 and 8 have per-bit pull-up selection
// - Ports 0,1,3,4 reset to input, pull-ups off, outputs floating
// - Port 2 pull-ups cleared at reset
// - Single-chip reset: ports 5-8 input, pulls off; port A pulls off
// - Processor mode forces port 5 bits 0-4 to strobes and top address
// - Processor mode drives address 0-7 on port 6, 8-15 on port 7
// - Processor mode uses port 8 as data bus, starting as input
// - Ports 7 and A enable pulls per bit, with one up or down choice per port, never mixed
// - Port 7 presents latched data on IRQ2 or timer 1, 2, 4 events
// - Reset pin is open drain, driven low by software reset when latch 0
// - Reset interrupt waits until the clock has stabilised
//
// The placing of the registers and the APB slave port are this design's own decisions.
`default_nettype none
module ppc_port_ctrl
  import ppc_pkg::*;
#(
  parameter int STABLE_CYCLES = OSC_STABLE_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [NUM_BIDIR-1:0][7:0] gp_pin_in,
  output ppc_drive_type                  gp_pin_drive,
  output ppc_pull_type                   pull_enable,
  input  wire logic [4:0]                port2_pin_in,
  input  wire logic [7:0]                analog_port_pin_in,
  input  wire logic                      reset_pin_active_low_in,
  output logic                           reset_pin_active_low_out,
  output logic                           reset_pin_active_low_oe,
  input  wire logic                      memory_mode_select_pin,
  input  wire ppc_ext_req_type           ext_req,
  output logic      [7:0]                ext_rdata,
  input  wire logic                      irq2_event,
  input  wire logic                      tmr1_event,
  input  wire logic                      tmr2_event,
  input  wire logic                      tmr4_event,
  output logic                           reset_irq_ready
);
  import ppc_pkg::*;

  localparam int SYNC_W = NUM_BIDIR * 8 + 5 + 8 + 2;

  logic [7:0]  out_latch [NUM_BIDIR];
  logic [7:0]  dir_bits [NUM_BIDIR];
  logic [7:0]  pullup_sel [NUM_BIDIR];
  logic [8:0]  p7_pud;
  logic [8:0]  pa_pud;
  logic [7:0]  sync_en;
  ppc_src_type sync_src;
  logic [7:0]  sync_data;
  logic        p2_rst_latch;
  logic [15:0] swrst_cnt;
  logic [31:0] stable_cnt;
  logic        strap_done;
  logic        proc_mode;
  logic [SYNC_W-1:0] pins_sync;
  logic [NUM_BIDIR-1:0][7:0] gp_sync;
  logic [4:0]  p2_sync;
  logic [7:0]  pa_sync;
  logic        rst_pin_sync;
  logic        mode_pin_sync;
  logic        wr_go;
  logic        rd_go;
  logic        addr_ok;
  logic [31:0] rd_value;
  logic        trig;

  // Every pin input crosses in through two flops
  ppc_sync #(.WIDTH(SYNC_W)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({gp_pin_in, port2_pin_in, analog_port_pin_in,
                reset_pin_active_low_in, memory_mode_select_pin}),
    .sync_out (pins_sync)
  );
  assign {gp_sync, p2_sync, pa_sync, rst_pin_sync, mode_pin_sync} = pins_sync;

  // Pin value as software sees it: latch where driven, pin otherwise
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                            input logic [7:0] lat,
                                            input logic [7:0] pin,
                                            input logic [7:0] msk);
    port_view = ((dir & lat) | (~dir & pin)) & msk;
  endfunction

  // Slot index of a register within a bank of eight words
  function automatic int slot(input logic [11:0] a, input logic [11:0] b);
    slot = int'(a[4:2] - b[4:2]);
  endfunction

  function automatic logic in_bank(input logic [11:0] a,
                                   input logic [11:0] b);
    in_bank = (a[11:5] == b[11:5]);
  endfunction

  // APB handshake: one wait state, pready from a flop
  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && !pready && !pwrite;
  assign addr_ok = in_bank(paddr, OFS_OUT_BASE) ||
                   in_bank(paddr, OFS_DIR_BASE) ||
                   in_bank(paddr, OFS_PULL_BASE) ||
                   paddr == OFS_P2_DATA || paddr == OFS_PA_DATA ||
                   paddr == OFS_P7_PUD || paddr == OFS_PA_PUD ||
                   paddr == OFS_SYNC || paddr == OFS_SWRST ||
                   paddr == OFS_STATUS;

  // Read data mux
  always_comb
  begin
    rd_value = '0;
    if (in_bank(paddr, OFS_OUT_BASE) && paddr < OFS_P2_DATA)
      rd_value[7:0] = port_view(dir_bits[slot(paddr, OFS_OUT_BASE)],
                               out_latch[slot(paddr, OFS_OUT_BASE)],
                               gp_sync[slot(paddr, OFS_OUT_BASE)],
                               PORT_MASK[slot(paddr, OFS_OUT_BASE)]);
    else if (in_bank(paddr, OFS_DIR_BASE))
      rd_value[7:0] = dir_bits[slot(paddr, OFS_DIR_BASE)];
    else if (in_bank(paddr, OFS_PULL_BASE))
      rd_value[7:0] = pullup_sel[slot(paddr, OFS_PULL_BASE)];
    else if (paddr == OFS_P2_DATA)
      rd_value[7:0] = {rst_pin_sync, 2'b00, p2_sync};
    else if (paddr == OFS_PA_DATA)
      rd_value[7:0] = pa_sync;
    else if (paddr == OFS_P7_PUD)
      rd_value[8:0] = p7_pud;
    else if (paddr == OFS_PA_PUD)
      rd_value[8:0] = pa_pud;
    else if (paddr == OFS_SYNC)
      rd_value[9:0] = {sync_src, sync_en};
    else if (paddr == OFS_SWRST)
      rd_value[0] = (swrst_cnt != '0);
    else if (paddr == OFS_STATUS)
    begin
      rd_value[STAT_PROC_BIT] = proc_mode;
      rd_value[STAT_READY_BIT] = reset_irq_ready;
    end
  end

  // Bus answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_go)
        prdata <= rd_value;
    end
  end

  // Port latches, direction and pull-up selections
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_BIDIR; i++)
      begin
        out_latch[i] <= RST_ZERO;
        dir_bits[i] <= RST_ZERO;
        pullup_sel[i] <= RST_ZERO;
      end
      p2_rst_latch <= RST_P2_LATCH;
    end
    else if (wr_go)
    begin
      if (in_bank(paddr, OFS_OUT_BASE) && paddr < OFS_P2_DATA)
        out_latch[slot(paddr, OFS_OUT_BASE)] <=
          pwdata[7:0] & PORT_MASK[slot(paddr, OFS_OUT_BASE)];
      if (in_bank(paddr, OFS_DIR_BASE))
        dir_bits[slot(paddr, OFS_DIR_BASE)] <=
          pwdata[7:0] & PORT_MASK[slot(paddr, OFS_DIR_BASE)];
      if (in_bank(paddr, OFS_PULL_BASE) &&
          slot(paddr, OFS_PULL_BASE) == PULL_IDX_P2)
        pullup_sel[PULL_IDX_P2] <= pwdata[7:0] & P2_MASK;
      else if (in_bank(paddr, OFS_PULL_BASE))
        pullup_sel[slot(paddr, OFS_PULL_BASE)] <=
          pwdata[7:0] & PORT_MASK[slot(paddr, OFS_PULL_BASE)];
      if (paddr == OFS_P2_DATA)
        p2_rst_latch <= pwdata[P2_RST_BIT];
    end
  end

  // One up/down choice per port keeps the two kinds from mixing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p7_pud <= '0;
      pa_pud <= '0;
    end
    else if (wr_go && paddr == OFS_P7_PUD)
      p7_pud <= pwdata[8:0];
    else if (wr_go && paddr == OFS_PA_PUD)
      pa_pud <= pwdata[8:0];
  end

  // Synchronous output: copy the port 7 latch on the chosen event
  always_comb
  begin
    case (sync_src)
      PPC_SRC_IRQ2: trig = irq2_event;
      PPC_SRC_TMR1: trig = tmr1_event;
      PPC_SRC_TMR2: trig = tmr2_event;
      PPC_SRC_TMR4: trig = tmr4_event;
      default:      trig = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_en <= RST_ZERO;
      sync_src <= PPC_SRC_IRQ2;
      sync_data <= RST_ZERO;
    end
    else
    begin
      if (wr_go && paddr == OFS_SYNC)
      begin
        sync_en <= pwdata[7:0];
        sync_src <= ppc_src_type'(pwdata[SYNC_SRC_LSB +: 2]);
      end
      if (trig)
        sync_data <= out_latch[IDX_P7];
    end
  end

  // Software reset hold-off; only drives the pin with a zero latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      swrst_cnt <= '0;
    else if (wr_go && paddr == OFS_SWRST && pwdata[0])
      swrst_cnt <= 16'(SWRST_LOW_CYC);
    else if (swrst_cnt != '0)
      swrst_cnt <= swrst_cnt - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_pin_active_low_out <= 1'b0;
      reset_pin_active_low_oe <= 1'b0;
    end
    else
    begin
      reset_pin_active_low_out <= 1'b0;
      reset_pin_active_low_oe <= (swrst_cnt != '0) && !p2_rst_latch;
    end
  end

  // Oscillator wait after release, then ready; strap capture falls inside the wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stable_cnt <= '0;
      reset_irq_ready <= 1'b0;
    end
    else if (stable_cnt < 32'(STABLE_CYCLES))
      stable_cnt <= stable_cnt + 32'h1;
    else
      reset_irq_ready <= 1'b1;
  end

  // Mode pin is taken once, after the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      proc_mode <= 1'b0;
      strap_done <= 1'b0;
    end
    else if (!strap_done && stable_cnt == 32'(STRAP_CYC))
    begin
      proc_mode <= mode_pin_sync;
      strap_done <= 1'b1;
    end
  end

  // Pin drive and pull outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_pin_drive <= '0;
      pull_enable <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_BIDIR; i++)
      begin
        gp_pin_drive.level[i] <= out_latch[i];
        gp_pin_drive.enable[i] <= dir_bits[i] & PORT_MASK[i];
        pull_enable.up[i] <= pullup_sel[i] & PORT_MASK[i];
      end
      gp_pin_drive.level[IDX_P7] <= (sync_en & sync_data) |
                                    (~sync_en & out_latch[IDX_P7]);
      pull_enable.up[IDX_P7] <= p7_pud[PUD_DOWN_BIT] ? RST_ZERO
                                : p7_pud[7:0];
      pull_enable.p7_down <= p7_pud[PUD_DOWN_BIT] ? p7_pud[7:0]
                             : RST_ZERO;
      pull_enable.p2_up <= pullup_sel[PULL_IDX_P2] & P2_MASK;
      pull_enable.pa_up <= pa_pud[PUD_DOWN_BIT] ? RST_ZERO : pa_pud[7:0];
      pull_enable.pa_down <= pa_pud[PUD_DOWN_BIT] ? pa_pud[7:0] : RST_ZERO;
      if (proc_mode)
      begin
        gp_pin_drive.level[IDX_P5] <= {3'b000, ext_req.addr[17:16],
                                       ext_req.cs_n, ext_req.rd_n,
                                       ext_req.wr_n};
        gp_pin_drive.enable[IDX_P5] <= PORT_MASK[IDX_P5];
        gp_pin_drive.level[IDX_P6] <= ext_req.addr[7:0];
        gp_pin_drive.enable[IDX_P6] <= PORT_MASK[IDX_P6];
        gp_pin_drive.level[IDX_P7] <= ext_req.addr[15:8];
        gp_pin_drive.enable[IDX_P7] <= PORT_MASK[IDX_P7];
        // Data bus floats unless a write is in flight
        gp_pin_drive.level[IDX_P8] <= ext_req.wdata;
        gp_pin_drive.enable[IDX_P8] <=
          {8{!ext_req.cs_n && !ext_req.wr_n}};
      end
    end
  end

  // Read data from the external bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_rdata <= '0;
    else
      ext_rdata <= gp_sync[IDX_P8];
  end

  chk_port5_width: assert property (@(posedge pclk) disable iff (!presetn)
    gp_pin_drive.enable[IDX_P5][7:5] == 3'b000)
    else $error("port 5 drives a bit that does not exist");

  chk_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == OFS_DIR_BASE && !proc_mode |-> ##2
    gp_pin_drive.enable[0] == ($past(pwdata[7:0], 2) & 8'h7f))
    else $error("port 0 enable does not follow its direction write");

  chk_pullup_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == OFS_PULL_BASE |-> ##2
    pull_enable.up[0] == ($past(pwdata[7:0], 2) & 8'h7f))
    else $error("port 0 pull-up does not follow its write");

  chk_reset_float: assert property (@(posedge pclk) disable iff (!presetn)
    stable_cnt == 32'h1 |-> gp_pin_drive.enable == '0 &&
    pull_enable == '0)
    else $error("pins driven or pulled right after reset");

  chk_bus_strobes: assert property (@(posedge pclk) disable iff (!presetn)
    proc_mode |=> gp_pin_drive.enable[IDX_P5] == 8'h1f &&
    gp_pin_drive.level[IDX_P5][2:0] == $past({ext_req.cs_n,
    ext_req.rd_n, ext_req.wr_n}))
    else $error("strobes not on port 5 in processor mode");

  chk_bus_address: assert property (@(posedge pclk) disable iff (!presetn)
    proc_mode |=> gp_pin_drive.level[IDX_P7] == $past(ext_req.addr[15:8])
    && gp_pin_drive.level[IDX_P6] == $past(ext_req.addr[7:0]))
    else $error("address not on ports 6 and 7");

  chk_data_float: assert property (@(posedge pclk) disable iff (!presetn)
    proc_mode && ext_req.wr_n |=> gp_pin_drive.enable[IDX_P8] == '0)
    else $error("data bus driven outside a write");

  chk_pull_mix: assert property (@(posedge pclk) disable iff (!presetn)
    (pull_enable.up[IDX_P7] & pull_enable.p7_down) == '0 &&
    (pull_enable.pa_up & pull_enable.pa_down) == '0)
    else $error("pull-up and pull-down mixed on one port");

  chk_sync_out: assert property (@(posedge pclk) disable iff (!presetn)
    trig && sync_en[0] && !proc_mode ##1 !proc_mode |=>
    gp_pin_drive.level[IDX_P7][0] == $past(out_latch[IDX_P7][0], 2))
    else $error("synchronous output did not present latched data");

  chk_rst_pin: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go && paddr == OFS_SWRST && pwdata[0] && !p2_rst_latch |=>
    ##1 reset_pin_active_low_oe && !reset_pin_active_low_out)
    else $error("software reset did not pull the reset pin low");

  chk_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
    reset_irq_ready |-> stable_cnt == 32'(STABLE_CYCLES))
    else $error("reset interrupt released before clock settled");
endmodule // ppc_port_ctrl
`default_nettype wire

/* File: ppc_sync.sv */
// Two-stage synchroniser for pin inputs
`default_nettype none
module ppc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // ppc_sync
`default_nettype wire

/* File: tb_port_pin_control_and_reset_pin.sv */
// Testbench for the port pin control block
`default_nettype none
module tb_port_pin_control_and_reset_pin;
  import ppc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_BIDIR-1:0][7:0] gp_pin_in;
  logic [NUM_BIDIR-1:0][7:0] board_level;
  ppc_drive_type drv;
  ppc_pull_type pul;
  logic rst_in;
  logic rst_out;
  logic rst_oe;
  logic mode_pin = 1'b0;
  ppc_ext_req_type ext_req = '1;
  logic [7:0] ext_rdata;
  logic [3:0] ev = 4'h0;
  logic irq_rdy;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;

  ppc_port_ctrl #(.STABLE_CYCLES(20)) i_ppc_port_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gp_pin_in(gp_pin_in),
    .gp_pin_drive(drv), .pull_enable(pul), .port2_pin_in(5'h15),
    .analog_port_pin_in(8'hc3), .reset_pin_active_low_in(rst_in),
    .reset_pin_active_low_out(rst_out), .reset_pin_active_low_oe(rst_oe),
    .memory_mode_select_pin(mode_pin), .ext_req(ext_req),
    .ext_rdata(ext_rdata), .irq2_event(ev[0]), .tmr1_event(ev[1]),
    .tmr2_event(ev[2]), .tmr4_event(ev[3]), .reset_irq_ready(irq_rdy));

  ppc_board_model i_ppc_board_model (
    .pclk(pclk), .gp_pin_drive(drv), .reset_pin_active_low_oe(rst_oe),
    .board_level(board_level), .mem_rdata(8'h69), .gp_pin_in(gp_pin_in),
    .reset_pin_active_low_in(rst_in));

  // 40 MHz clock and a cycle ceiling against hangs
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp,
                     input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(nm, 64'(exp), 64'(r));
  endtask

  // Mode strap is set only while reset is held
  task automatic do_reset(input logic proc);
    presetn <= 1'b0;
    mode_pin <= proc;
    cyc(2);
    presetn <= 1'b1;
    cyc(10);
    chk("irq_ready_early", 0, 64'(irq_rdy));
    cyc(15);
    chk("irq_ready", 1, 64'(irq_rdy));
  endtask

  initial
  begin
    logic [7:0] m;
    logic [7:0] v;
    int c;
    for (int s = 0; s < NUM_BIDIR; s++)
      board_level[s] = 8'h3c ^ 8'(s);
    @(posedge pclk);
    do_reset(1'b0);
    chk("reset_drive", 0, drv.enable);
    chk("reset_pull", 0, pul.up);
    chk("reset_pull2", 0,
        {pul.p2_up, pul.p7_down, pul.pa_up, pul.pa_down});
    rd("status", OFS_STATUS, 33'h2);
    // Per-bit direction, read-back mix and pull-up select on every slot
    for (int s = 0; s < NUM_BIDIR; s++)
    begin
      m = PORT_MASK[s];
      wr(OFS_OUT_BASE + 12'(4 * s), 32'ha5);
      wr(OFS_DIR_BASE + 12'(4 * s), 32'h0f);
      cyc(3);
      chk("dir_en", 64'(8'h0f & m), 64'(drv.enable[s]));
      chk("dir_lvl", 64'(8'h05 & m), 64'(drv.level[s] & 8'h0f));
      rd("readback", OFS_OUT_BASE + 12'(4 * s),
         33'((8'h05 | (8'hf0 & board_level[s])) & m));
      wr(OFS_DIR_BASE + 12'(4 * s), 32'hff);
      wr(OFS_PULL_BASE + 12'(4 * s), 32'hff);
      cyc(2);
      chk("width", 64'(m), 64'(drv.enable[s]));
      if (s == PULL_IDX_P2)
        chk("pull_p2", 64'(P2_MASK), 64'(pul.p2_up));
      else
        chk("pull_up", 64'(m), 64'(pul.up[s]));
    end
    rd("port2", OFS_P2_DATA, 33'h95);
    rd("port_a", OFS_PA_DATA, 33'hc3);
    rd("unmapped", 12'h0fc, 33'h1_0000_0000);
    // Uniform pull direction per port, never mixed
    wr(OFS_P7_PUD, 32'h10f);
    cyc(2);
    chk("p7_down", 64'h0f, {pul.up[IDX_P7], pul.p7_down});
    wr(OFS_P7_PUD, 32'h0f0);
    wr(OFS_PA_PUD, 32'h1ff);
    cyc(2);
    chk("p7_up", 64'hf000, {pul.up[IDX_P7], pul.p7_down});
    chk("pa_down", 64'h00ff, {pul.pa_up, pul.pa_down});
    // Each trigger source alone presents the latch on port 7
    for (int k = 0; k < 4; k++)
    begin
      v = 8'h11 * 8'(k + 1);
      wr(OFS_SYNC, 32'hff | (k << SYNC_SRC_LSB));
      wr(OFS_OUT_BASE + 12'(4 * IDX_P7), 32'(v));
      ev <= 4'(1 << k);
      cyc(1);
      ev <= 4'h0;
      cyc(2);
      chk("sync_hit", 64'(v), 64'(drv.level[IDX_P7]));
      wr(OFS_OUT_BASE + 12'(4 * IDX_P7), 32'(~v));
      ev <= 4'hf & ~4'(1 << k);
      cyc(1);
      ev <= 4'h0;
      cyc(2);
      chk("sync_hold", 64'(v), 64'(drv.level[IDX_P7]));
    end
    // Software reset pulls the pin only when its latch bit is zero
    wr(OFS_SWRST, 32'h1);
    cyc(5);
    chk("swrst_latch1", 0, 64'(rst_oe));
    // Let the first count run out so the length is measured from a clean start
    cyc(SWRST_LOW_CYC);
    wr(OFS_P2_DATA, 32'h0);
    wr(OFS_SWRST, 32'h1);
    c = 0;
    while (rst_oe !== 1'b1 && c < 10)
    begin
      cyc(1);
      c++;
    end
    c = 0;
    while (rst_oe === 1'b1 && c < 100)
    begin
      cyc(1);
      c++;
    end
    chk("swrst_len", 64'(SWRST_LOW_CYC), 64'(c));
    chk("rst_out", 0, 64'(rst_out));
    // Processor mode: bus takeover ignores direction registers
    do_reset(1'b1);
    chk("p8_start", 0, 64'(drv.enable[IDX_P8]));
    rd("status_proc", OFS_STATUS, 33'h3);
    ext_req <= {1'b0, 1'b1, 1'b0, 18'h2a5c3, 8'h96};
    cyc(3);
    chk("p5_en", 64'h1f, 64'(drv.enable[IDX_P5]));
    chk("p5_lvl", 64'h12, 64'(drv.level[IDX_P5] & 8'h1f));
    chk("addr_en", 64'hffff, {drv.enable[IDX_P7], drv.enable[IDX_P6]});
    chk("addr_lvl", 64'ha5c3, {drv.level[IDX_P7], drv.level[IDX_P6]});
    chk("data_out", 64'hff96, {drv.enable[IDX_P8], drv.level[IDX_P8]});
    ext_req <= {1'b1, 1'b0, 1'b0, 18'h2a5c3, 8'h00};
    cyc(6);
    chk("data_in_en", 0, 64'(drv.enable[IDX_P8]));
    chk("ext_rdata", 64'h69, 64'(ext_rdata));
    summarize();
  end
endmodule // tb_port_pin_control_and_reset_pin
`default_nettype wire
